/* File: src/wmf_defines.svh */
// offsets, field positions, reset values and counts of the fua write block
// assumes inclusion by the principal design file
`ifndef WMF_DEFINES_SVH
`define WMF_DEFINES_SVH
// task file and own registers, word index on the 4-bit register port
`define OFF_DATA      4'h0
`define OFF_ERROR     4'h1
`define OFF_SECCNT    4'h2
`define OFF_SECNUM    4'h3
`define OFF_CYLLO     4'h4
`define OFF_CYLHI     4'h5
`define OFF_DEVHEAD   4'h6
`define OFF_CMDSTAT   4'h7
`define OFF_DEVCTL    4'h8
`define OFF_EVENTS    4'h9
`define OFF_EVMASK    4'hA
`define OFF_BLOCKSIZE 4'hB
// command opcode
`define OP_WRITE_MULT_FUA_EXT 8'hCE
// error register fields
`define ERR_SECTOR_NOT_FOUND 4
`define ERR_CMD_ABORTED      2
// status register fields
`define ST_BSY 7
`define ST_RDY 6
`define ST_DSC 4
`define ST_DRQ 3
`define ST_ERR 0
// device control high-order-byte select
`define DEVCTL_HOB 7
// event bits
`define EV_BLOCK 0
`define EV_DONE  1
`define EV_ERROR 2
// counts and reset values
`define WORDS_PER_SECTOR 9'h100
`define ZERO_LEN_SECTORS 17'h1_0000
`define BLOCKSIZE_RST    8'h01
`define EVMASK_RST       3'h0
`endif

/* File: src/wmf_pkg.sv */
// types shared by the fua multiple write block
// assumes the defines header sits beside it
`default_nettype none
package wmf_pkg;
	// command sequencer states
	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_XFER   = 2'b01,
		ST_COMMIT = 2'b10
	} seq_state_t;
endpackage
`default_nettype wire

/* File: src/write_multiple_fua_ext_cmd.sv */
// device-side sequencer of the 48-bit multiple write with forced commit
// assumes host strobes and media handshake are synchronous to mclk
//
// Notes on behaviour
// - host writes CEh; device decodes it as 48-bit multiple write with commit
// - combined length of zero means 65,536 sectors
// - sectors move from host to device and are then written to media
// - all data is committed to media before ending status appears
// - one interrupt per multiple block, not per sector
// - sector data passes the data register one 16-bit word per access
// - failing address shows low bytes at select 0, high bytes at select 1
// - error register holds only sector-not-found and aborted bits
// - ending status: busy, fault, corrected zero; ready, seek, error valid
`timescale 1ns/1ns
`default_nettype none
`include "wmf_defines.svh"

module write_multiple_fua_ext_cmd
	import wmf_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rst_b,
	input  wire logic [3:0]  regAddr,
	input  wire logic [15:0] regWrData,
	input  wire logic        regWrite,
	input  wire logic        regRead,
	output logic      [15:0] regRdData,
	output logic             irq,
	output logic      [15:0] mediaWord,
	output logic             mediaWordValid,
	output logic      [47:0] mediaLba,
	output logic             mediaCommit,
	input  wire logic        mediaCommitDone,
	input  wire logic        mediaError,
	input  wire logic [47:0] mediaErrorLba
);

	logic       rstSync1;
	logic       rstSync2;
	seq_state_t state;
	seq_state_t next_state;
	logic [7:0]  secCntCur, secCntPrev;
	logic [7:0]  secNumCur, secNumPrev;
	logic [7:0]  cylLoCur, cylLoPrev;
	logic [7:0]  cylHiCur, cylHiPrev;
	logic [7:0]  devHead;
	logic [7:0]  devCtl;
	logic [7:0]  blockSize;
	logic [2:0]  events;
	logic [2:0]  evMask;
	logic        errSnf;
	logic        errAbt;
	logic        errFlag;
	logic        seekDone;
	logic [16:0] secLeft;
	logic [8:0]  wordLeft;
	logic [7:0]  blkLeft;
	logic [47:0] curLba;
	logic        cmdWrite;
	logic        startCmd;
	logic        badCmd;
	logic        wordTaken;
	logic        sectorEnd;
	logic        lastSector;
	logic        blockEnd;
	logic        failNow;
	logic        doneNow;
	logic [2:0]  eventSet;
	logic [16:0] lenReq;
	logic [7:0]  statusByte;
	logic [7:0]  errorByte;
	logic        hob;

	// reset release through two flops
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rstSync1 <= 1'b0;
			rstSync2 <= 1'b0;
		end else begin
			rstSync1 <= 1'b1;
			rstSync2 <= rstSync1;
		end
	end

	// command decode and transfer conditions
	assign cmdWrite  = regWrite && regAddr == `OFF_CMDSTAT;
	assign startCmd  = cmdWrite && state == ST_IDLE
		&& regWrData[7:0] == `OP_WRITE_MULT_FUA_EXT;
	assign badCmd    = cmdWrite && state == ST_IDLE && !startCmd;
	assign wordTaken = state == ST_XFER && regWrite
		&& regAddr == `OFF_DATA;
	assign sectorEnd  = wordTaken && wordLeft == 9'h001;
	assign lastSector = secLeft == 17'h0_0001;
	assign blockEnd   = sectorEnd && (blkLeft == 8'h01 || lastSector);
	assign failNow    = mediaError && state != ST_IDLE;
	assign doneNow    = state == ST_COMMIT && mediaCommitDone && !failNow;
	assign hob        = devCtl[`DEVCTL_HOB];

	// zero in both count bytes asks for the largest transfer
	always_comb begin
		lenReq = {1'b0, secCntPrev, secCntCur};
		if (lenReq == 17'h0_0000) begin
			lenReq = `ZERO_LEN_SECTORS;
		end
	end

	// sequencer
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (startCmd) begin
					next_state = ST_XFER;
				end
			end
			ST_XFER: begin
				if (failNow) begin
					next_state = ST_IDLE;
				end else if (sectorEnd && lastSector) begin
					next_state = ST_COMMIT;
				end
			end
			ST_COMMIT: begin
				if (failNow || mediaCommitDone) begin
					next_state = ST_IDLE;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rstSync2) begin
		if (!rstSync2) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// task file bytes: a write pushes current into previous
	always_ff @(posedge mclk or negedge rstSync2) begin
		if (!rstSync2) begin
			secCntCur  <= 8'h00;
			secCntPrev <= 8'h00;
			secNumCur  <= 8'h00;
			secNumPrev <= 8'h00;
			cylLoCur   <= 8'h00;
			cylLoPrev  <= 8'h00;
			cylHiCur   <= 8'h00;
			cylHiPrev  <= 8'h00;
		end else if (failNow) begin
			// failing address and sectors not written
			{secNumPrev, secNumCur} <= {mediaErrorLba[31:24],
				mediaErrorLba[7:0]};
			{cylLoPrev, cylLoCur} <= {mediaErrorLba[39:32],
				mediaErrorLba[15:8]};
			{cylHiPrev, cylHiCur} <= {mediaErrorLba[47:40],
				mediaErrorLba[23:16]};
			{secCntPrev, secCntCur} <= secLeft[15:0];
		end else if (doneNow) begin
			secCntCur  <= 8'h00;
			secCntPrev <= 8'h00;
		end else if (regWrite && state == ST_IDLE) begin
			case (regAddr)
				`OFF_SECCNT: begin
					secCntPrev <= secCntCur;
					secCntCur  <= regWrData[7:0];
				end
				`OFF_SECNUM: begin
					secNumPrev <= secNumCur;
					secNumCur  <= regWrData[7:0];
				end
				`OFF_CYLLO: begin
					cylLoPrev <= cylLoCur;
					cylLoCur  <= regWrData[7:0];
				end
				`OFF_CYLHI: begin
					cylHiPrev <= cylHiCur;
					cylHiCur  <= regWrData[7:0];
				end
				default: begin
				end
			endcase
		end
	end

	// control registers that steer the block
	always_ff @(posedge mclk or negedge rstSync2) begin
		if (!rstSync2) begin
			devHead   <= 8'h00;
			devCtl    <= 8'h00;
			blockSize <= `BLOCKSIZE_RST;
			evMask    <= `EVMASK_RST;
		end else if (regWrite) begin
			case (regAddr)
				`OFF_DEVHEAD: devHead <= regWrData[7:0];
				`OFF_DEVCTL: devCtl <= regWrData[7:0];
				`OFF_BLOCKSIZE: begin
					if (state == ST_IDLE && regWrData[7:0] != 8'h00) begin
						blockSize <= regWrData[7:0];
					end
				end
				`OFF_EVMASK: evMask <= regWrData[2:0];
				default: begin
				end
			endcase
		end
	end

	// sector, word and block counters with running address
	always_ff @(posedge mclk or negedge rstSync2) begin
		if (!rstSync2) begin
			secLeft  <= 17'h0_0000;
			wordLeft <= 9'h000;
			blkLeft  <= 8'h00;
			curLba   <= 48'h0000_0000_0000;
		end else if (startCmd) begin
			secLeft  <= lenReq;
			wordLeft <= `WORDS_PER_SECTOR;
			blkLeft  <= blockSize;
			curLba   <= {cylHiPrev, cylLoPrev, secNumPrev,
				cylHiCur, cylLoCur, secNumCur};
		end else if (wordTaken) begin
			if (sectorEnd) begin
				secLeft  <= secLeft - 17'h0_0001;
				wordLeft <= `WORDS_PER_SECTOR;
				curLba   <= curLba + 48'h0000_0000_0001;
				blkLeft  <= blockEnd ? blockSize
					: blkLeft - 8'h01;
			end else begin
				wordLeft <= wordLeft - 9'h001;
			end
		end
	end

	// each host word goes to the media with its sector address
	always_ff @(posedge mclk or negedge rstSync2) begin
		if (!rstSync2) begin
			mediaWord      <= 16'h0000;
			mediaWordValid <= 1'b0;
			mediaLba       <= 48'h0000_0000_0000;
			mediaCommit    <= 1'b0;
		end else begin
			mediaWordValid <= wordTaken;
			mediaCommit    <= next_state == ST_COMMIT;
			if (wordTaken) begin
				mediaWord <= regWrData;
				mediaLba  <= curLba;
			end
		end
	end

	// error and status bits of the command
	always_ff @(posedge mclk or negedge rstSync2) begin
		if (!rstSync2) begin
			errSnf   <= 1'b0;
			errAbt   <= 1'b0;
			errFlag  <= 1'b0;
			seekDone <= 1'b1;
		end else if (startCmd) begin
			errSnf  <= 1'b0;
			errAbt  <= 1'b0;
			errFlag <= 1'b0;
		end else if (failNow) begin
			errSnf   <= 1'b1;
			errFlag  <= 1'b1;
			seekDone <= 1'b1;
		end else if (badCmd) begin
			errAbt  <= 1'b1;
			errFlag <= 1'b1;
		end
	end

	// busy covers the commit, so no ending status before it ends
	always_comb begin
		statusByte              = 8'h00;
		statusByte[`ST_BSY]     = state == ST_COMMIT;
		statusByte[`ST_RDY]     = 1'b1;
		statusByte[`ST_DSC]     = seekDone;
		statusByte[`ST_DRQ]     = state == ST_XFER;
		statusByte[`ST_ERR]     = errFlag;
		errorByte                        = 8'h00;
		errorByte[`ERR_SECTOR_NOT_FOUND] = errSnf;
		errorByte[`ERR_CMD_ABORTED]      = errAbt;
	end

	// sticky events: set wins over a write-one clear
	assign eventSet[`EV_BLOCK] = blockEnd && !(sectorEnd && lastSector)
		&& !failNow;
	assign eventSet[`EV_DONE]  = doneNow;
	assign eventSet[`EV_ERROR] = failNow || badCmd;

	always_ff @(posedge mclk or negedge rstSync2) begin
		if (!rstSync2) begin
			events <= 3'h0;
		end else begin
			if (regWrite && regAddr == `OFF_EVENTS) begin
				events <= (events & ~regWrData[2:0]) | eventSet;
			end else begin
				events <= events | eventSet;
			end
		end
	end

	assign irq = |(events & evMask);

	// read data one cycle after the strobe
	always_ff @(posedge mclk or negedge rstSync2) begin
		if (!rstSync2) begin
			regRdData <= 16'h0000;
		end else if (regRead) begin
			case (regAddr)
				`OFF_ERROR: regRdData <= {8'h00, errorByte};
				`OFF_SECCNT: regRdData <= {8'h00,
					hob ? secCntPrev : secCntCur};
				`OFF_SECNUM: regRdData <= {8'h00,
					hob ? secNumPrev : secNumCur};
				`OFF_CYLLO: regRdData <= {8'h00,
					hob ? cylLoPrev : cylLoCur};
				`OFF_CYLHI: regRdData <= {8'h00,
					hob ? cylHiPrev : cylHiCur};
				`OFF_DEVHEAD: regRdData <= {8'h00, devHead};
				`OFF_CMDSTAT: regRdData <= {8'h00, statusByte};
				`OFF_DEVCTL: regRdData <= {8'h00, devCtl};
				`OFF_EVENTS: regRdData <= {13'h0000, events};
				`OFF_EVMASK: regRdData <= {13'h0000, evMask};
				`OFF_BLOCKSIZE: regRdData <= {8'h00, blockSize};
				default: regRdData <= 16'h0000;
			endcase
		end else begin
			regRdData <= 16'h0000;
		end
	end

endmodule // write_multiple_fua_ext_cmd

`default_nettype wire

/* File: dv/wmf_sva.sv */
// port checker of the fua write sequencer
// assumes bind onto the design top below
`timescale 1ns/1ns
`default_nettype none
module wmf_sva (
	input wire logic        mclk,
	input wire logic        rst_b,
	input wire logic [3:0]  regAddr,
	input wire logic [15:0] regWrData,
	input wire logic        regWrite,
	input wire logic        regRead,
	input wire logic [15:0] regRdData,
	input wire logic [15:0] mediaWord,
	input wire logic        mediaWordValid,
	input wire logic        mediaCommit,
	input wire logic        mediaCommitDone,
	input wire logic        mediaError
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	a_word_from_host: assert property (mediaWordValid |-> $past(regWrite)
		&& $past(regAddr) == 4'h0 && mediaWord == $past(regWrData))
		else $error("stray media word");
	a_no_word_commit: assert property (mediaCommit && $past(mediaCommit)
		|-> !mediaWordValid) else $error("word during commit");
	a_commit_holds: assert property (mediaCommit && !mediaCommitDone
		&& !mediaError |=> mediaCommit) else $error("commit dropped");
	a_commit_ends: assert property (mediaCommit && (mediaCommitDone
		|| mediaError) |=> !mediaCommit) else $error("commit stuck");
	a_err_bits: assert property ($past(regRead) && $past(regAddr) == 4'h1
		|-> (regRdData & 16'hFFEB) == 16'h0000) else $error("error bits");
	a_stat_zeros: assert property ($past(regRead) && $past(regAddr) == 4'h7
		|-> (regRdData & 16'hFF26) == 16'h0000) else $error("status bits");
	a_busy_commit: assert property ($past(regRead) && $past(mediaCommit)
		&& $past(regAddr) == 4'h7 |-> regRdData[7]) else $error("not busy");
	a_read_one_cycle: assert property (!$past(regRead)
		|-> regRdData == 16'h0000) else $error("read data stands");
endmodule // wmf_sva
bind write_multiple_fua_ext_cmd wmf_sva i_wmf_sva (.mclk(mclk), .rst_b(rst_b),
	.regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
	.regRead(regRead), .regRdData(regRdData), .mediaWord(mediaWord),
	.mediaWordValid(mediaWordValid), .mediaCommit(mediaCommit),
	.mediaCommitDone(mediaCommitDone), .mediaError(mediaError));
`default_nettype wire

/* File: dv/media_model.sv */
// media side model: commit answer and error injection
// assumes the bench sets latency and pulses failNow
`timescale 1ns/1ns
`default_nettype none
module media_model (
	input wire logic        mclk,
	input wire logic        rst_b,
	input wire logic        mediaCommit,
	input wire logic        failNow,
	input wire logic [7:0]  latency,
	input wire logic [47:0] failLba,
	output logic            mediaCommitDone,
	output logic            mediaError,
	output logic     [47:0] mediaErrorLba
);
	logic [7:0] waitCount;
	// done after latency plus one cycles of commit; address churns when not valid
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			waitCount <= 8'h00;
			mediaCommitDone <= 1'b0;
			mediaError <= 1'b0;
			mediaErrorLba <= 48'h0000_0000_0000;
		end else begin
			waitCount <= mediaCommit ? waitCount + 8'h01 : 8'h00;
			mediaCommitDone <= mediaCommit && waitCount == latency;
			mediaError <= failNow;
			mediaErrorLba <= failNow ? failLba : ~mediaErrorLba;
		end
	end
endmodule // media_model
`default_nettype wire

/* File: dv/write_multiple_fua_ext_cmd_tb.sv */
// bench of the fua write sequencer with media model
// assumes the design, checker and model files compiled first
`timescale 1ns/1ns
`default_nettype none
module write_multiple_fua_ext_cmd_tb;
	logic        mclk = 0, rst_b = 0, regWrite = 0, regRead = 0;
	logic        failNow = 0, irq, mediaCommit, done, merr;
	logic [3:0]  regAddr = 0;
	logic [7:0]  latency = 8'h14;
	logic [15:0] regWrData = 0, regRdData, rv;
	logic [47:0] failLba = 0, mediaLba, errLba;
	int          failures = 0, samples_checked = 0;
	always #4 mclk = ~mclk;
	write_multiple_fua_ext_cmd i_write_multiple_fua_ext_cmd (.mclk(mclk),
		.rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData),
		.regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
		.irq(irq), .mediaWord(), .mediaWordValid(), .mediaLba(mediaLba),
		.mediaCommit(mediaCommit), .mediaCommitDone(done),
		.mediaError(merr), .mediaErrorLba(errLba));
	media_model i_media_model (.mclk(mclk), .rst_b(rst_b),
		.mediaCommit(mediaCommit), .failNow(failNow), .latency(latency),
		.failLba(failLba), .mediaCommitDone(done), .mediaError(merr),
		.mediaErrorLba(errLba));
	task wr(input logic [3:0] a, input logic [15:0] d);
		regAddr <= a;
		regWrData <= d;
		regWrite <= 1'b1;
		@(posedge mclk);
		regWrite <= 1'b0;
		@(posedge mclk);
	endtask
	task rd(input logic [3:0] a);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge mclk);
		regRead <= 1'b0;
		#1 rv = regRdData;
		@(posedge mclk);
	endtask
	task chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("FAIL %0t got %h want %h", $time, got, exp);
		end
	endtask
	task words(input int n);
		for (int i = 0; i < n; i++) wr(4'h0, i[15:0]);
	endtask
	task load(input logic [15:0] cnt, input logic [47:0] lba);
		wr(4'h2, {8'h00, cnt[15:8]});
		wr(4'h2, {8'h00, cnt[7:0]});
		for (int a = 0; a < 3; a++) begin
			wr(4'h3 + a[3:0], {8'h00, lba[24 + 8 * a +: 8]});
			wr(4'h3 + a[3:0], {8'h00, lba[8 * a +: 8]});
		end
		wr(4'h7, 16'h00CE);
	endtask
	// idle values and an unmapped read
	task reset_values;
		rd(4'h7);
		chk(rv, 16'h0050);
		rd(4'hC);
		chk(rv, 16'h0000);
	endtask
	// three sectors, two per interrupt, slow commit
	task full_write;
		wr(4'hB, 16'h0002);
		wr(4'hA, 16'h0003);
		load(16'h0003, 48'h1234_5678_9ABC);
		rd(4'h7);
		chk(rv & 16'h0088, 16'h0008);
		words(1);
		chk(mediaLba[15:0], 16'h9ABC);
		chk(mediaLba[47:32], 16'h1234);
		words(511);
		repeat (2) @(posedge mclk);
		chk({15'h0000, irq}, 16'h0001);
		wr(4'h9, 16'h0001);
		chk({15'h0000, irq}, 16'h0000);
		words(256);
		rd(4'h7);
		chk(rv & 16'h0080, 16'h0080);
		for (int n = 0; mediaCommit && n < 300; n++) @(posedge mclk);
		@(posedge mclk);
		rd(4'h7);
		chk(rv, 16'h0050);
		rd(4'h9);
		chk(rv, 16'h0002);
		rd(4'h2);
		chk(rv, 16'h0000);
		wr(4'h9, 16'h0007);
	endtask
	// zero length, one sector, then a media error
	task media_fail;
		load(16'h0000, 48'hFEDC_BA98_7654);
		words(256);
		failLba <= 48'h0A0B_0C0D_0E0F;
		failNow <= 1'b1;
		@(posedge mclk);
		failNow <= 1'b0;
		repeat (3) @(posedge mclk);
		rd(4'h1);
		chk(rv, 16'h0010);
		rd(4'h7);
		chk(rv & 16'h0001, 16'h0001);
		for (int h = 0; h < 2; h++) begin
			wr(4'h8, {8'h00, h[0], 7'h00});
			rd(4'h2);
			chk(rv, 16'h00FF);
			for (int a = 0; a < 3; a++) begin
				rd(4'h3 + a[3:0]);
				chk(rv, {8'h00, failLba[24 * h + 8 * a +: 8]});
			end
		end
		wr(4'h8, 16'h0000);
		wr(4'h9, 16'h0007);
	endtask
	// foreign opcode is refused with abort
	task abort_cmd;
		wr(4'hA, 16'h0004);
		wr(4'h7, 16'h0030);
		rd(4'h1);
		chk(rv, 16'h0014);
		chk({15'h0000, irq}, 16'h0001);
		wr(4'h9, 16'h0004);
		chk({15'h0000, irq}, 16'h0000);
	endtask
	task print_verdict;
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// main sequence after reset
	initial begin
		repeat (12) @(posedge mclk);
		rst_b <= 1'b1;
		repeat (3) @(posedge mclk);
		reset_values;
		full_write;
		media_fail;
		abort_cmd;
		print_verdict;
	end
	// hang guard, well past the expected run
	initial begin
		#400000;
		failures++;
		print_verdict;
	end
endmodule // write_multiple_fua_ext_cmd_tb
`default_nettype wire
